// ### common/led_pkg.sv
// Constants and types shared by the status lamp encoder
package led_pkg;

   // Lamp colour codes, shared by every indicator
   typedef enum logic [1:0] {
      COL_OFF,
      COL_GREEN,
      COL_RED,
      COL_YELLOW
   } colour_t;

   // Clock and pattern timing
   localparam int  CLK_HZ         = 25000000;
   localparam int  FLASH_HALF_MS  = 500;
   localparam int  BLINK_HALF_MS  = 100;
   localparam int  FLASH_HALF_CYC = CLK_HZ / 1000 * FLASH_HALF_MS;
   localparam int  BLINK_HALF_CYC = CLK_HZ / 1000 * BLINK_HALF_MS;

   // Activity stretch, so a single-cycle traffic pulse shows on the link lamp; the serial lamp can miss it in a dark flash half
   localparam int  ACT_HOLD_MS    = 250;
   localparam int  ACT_HOLD_CYC   = CLK_HZ / 1000 * ACT_HOLD_MS;

endpackage

// ### src/pattern_gen.sv
// Square wave generator giving one lamp pattern phase
`timescale 1ns/1ns
module pattern_gen
   import led_pkg::*;
#(
   parameter int HALF_CYC = FLASH_HALF_CYC
) (
   // Clock and reset
   input  wire logic ref_clk,
   input  wire logic rst,
   // Pattern phase
   output logic      phase
);

   localparam int CW = $clog2(HALF_CYC + 1);

   logic [CW-1:0] cnt_r;
   logic          phase_r;

   // Refused at elaboration: a zero half period could never toggle
   if (HALF_CYC < 1) begin : g_half_check
      $error("pattern_gen: HALF_CYC must be at least one");
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         cnt_r   <= '0;
         phase_r <= 1'b0;
      end else if (cnt_r == CW'(HALF_CYC - 1)) begin
         cnt_r   <= '0;
         phase_r <= ~phase_r;
      end else begin
         cnt_r <= cnt_r + 1'b1;
      end
   end

   assign phase = phase_r;

endmodule

// ### src/activity_stretch.sv
// Retriggerable stretcher turning traffic pulses into a held level
`timescale 1ns/1ns
module activity_stretch
   import led_pkg::*;
#(
   parameter int HOLD_CYC = ACT_HOLD_CYC
) (
   // Clock and reset
   input  wire logic ref_clk,
   input  wire logic rst,
   // Traffic pulse in, held level out
   input  wire logic pulse,
   output logic      active
);

   localparam int CW = $clog2(HOLD_CYC + 1);

   logic [CW-1:0] cnt_r;

   // Refused at elaboration: a zero hold would hide every pulse
   if (HOLD_CYC < 1) begin : g_hold_check
      $error("activity_stretch: HOLD_CYC must be at least one");
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         cnt_r <= '0;
      end else if (pulse) begin
         cnt_r <= CW'(HOLD_CYC);
      end else if (cnt_r != '0) begin
         cnt_r <= cnt_r - 1'b1;
      end
   end

   assign active = (cnt_r != '0);

endmodule

// ### src/drive_status_led_encoder.sv
// Front panel lamp encoder for drive, safety, Ethernet and serial state
//
// Behaviour
// - Drive status lamp dark while the drive is unpowered.
// - Drive status lamp flashes green when stopped and ready.
// - Drive status lamp blinks green during transitory states.
// - Drive status lamp steady green while running settled.
// - Fault lamp flashes red on a warning.
// - Fault lamp steady red on an error.
// - Safety lamp steady yellow when safety function triggered.
// - Link lamp dark while no Ethernet link.
// - Link lamp steady green at 100 Mbit/s without traffic.
// - Link lamp blinks green with traffic at 100 Mbit/s.
// - Link lamp steady yellow at 10 Mbit/s without traffic.
// - Link lamp blinks yellow with traffic at 10 Mbit/s.
// - Network lamp dark while no IP address held.
// - Network lamp alternates green and red flashes during power-on test.
// - Network lamp steady green while Modbus TCP session controls command word.
// - Network lamp flashes green with valid IP but no controlling session.
// - Network lamp steady red on duplicate IP address.
// - Network lamp red when controlling session closed or timed out.
// - Serial lamp flashes yellow during serial Modbus traffic.
`timescale 1ns/1ns
module drive_status_led_encoder
   import led_pkg::*;
#(
   parameter int FLASH_HALF = FLASH_HALF_CYC,
   parameter int BLINK_HALF = BLINK_HALF_CYC,
   parameter int ACT_HOLD   = ACT_HOLD_CYC
) (
   // Clock and reset
   input  wire logic    ref_clk,
   input  wire logic    rst,
   // Drive state flags
   input  wire logic    drive_powered,
   input  wire logic    drive_ready,
   input  wire logic    drive_transitory,
   input  wire logic    drive_running,
   input  wire logic    drive_warning,
   input  wire logic    drive_error,
   input  wire logic    safety_triggered,
   // Embedded Ethernet state flags
   input  wire logic    eth_link_up,
   input  wire logic    eth_speed_100,
   input  wire logic    eth_traffic,
   input  wire logic    net_power_on_test,
   input  wire logic    net_ip_valid,
   input  wire logic    net_duplicate_ip,
   input  wire logic    net_session_active,
   input  wire logic    net_session_lost,
   // Serial link traffic
   input  wire logic    serial_traffic,
   // Lamp colours
   output colour_t      drive_status_indicator,
   output colour_t      fault_indicator,
   output colour_t      safety_trip_indicator,
   output colour_t      ethernet_link_indicator,
   output colour_t      network_status_indicator,
   output colour_t      serial_activity_indicator
);

   ////////////////////////////////////////////////////////////////////////////
   // Checks and pattern sources

   // Equal periods would make flashing and blinking look the same
   if (FLASH_HALF == BLINK_HALF) begin : g_period_check
      $error("flash and blink periods must differ");
   end

   logic flash_ph;
   logic blink_ph;
   logic eth_act;
   logic ser_act;

   pattern_gen #(.HALF_CYC(FLASH_HALF)) u_flash (
      .ref_clk (ref_clk),
      .rst     (rst),
      .phase   (flash_ph)
   );

   pattern_gen #(.HALF_CYC(BLINK_HALF)) u_blink (
      .ref_clk (ref_clk),
      .rst     (rst),
      .phase   (blink_ph)
   );

   activity_stretch #(.HOLD_CYC(ACT_HOLD)) u_eth_act (
      .ref_clk (ref_clk),
      .rst     (rst),
      .pulse   (eth_traffic),
      .active  (eth_act)
   );

   activity_stretch #(.HOLD_CYC(ACT_HOLD)) u_ser_act (
      .ref_clk (ref_clk),
      .rst     (rst),
      .pulse   (serial_traffic),
      .active  (ser_act)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Next lamp colours

   colour_t drv_nxt;
   colour_t flt_nxt;
   colour_t saf_nxt;
   colour_t lnk_nxt;
   colour_t net_nxt;
   colour_t ser_nxt;

   always_comb begin
      drv_nxt = COL_OFF;
      if (!drive_powered) begin
         drv_nxt = COL_OFF;
      end else if (drive_transitory) begin
         drv_nxt = blink_ph ? COL_GREEN : COL_OFF;
      end else if (drive_running) begin
         drv_nxt = COL_GREEN;
      end else if (drive_ready) begin
         drv_nxt = flash_ph ? COL_GREEN : COL_OFF;
      end
   end

   always_comb begin
      flt_nxt = COL_OFF;
      if (drive_error) begin
         flt_nxt = COL_RED;
      end else if (drive_warning) begin
         flt_nxt = flash_ph ? COL_RED : COL_OFF;
      end
   end

   always_comb begin
      saf_nxt = safety_triggered ? COL_YELLOW : COL_OFF;
   end

   always_comb begin
      lnk_nxt = COL_OFF;
      if (eth_link_up) begin
         if (eth_speed_100) begin
            lnk_nxt = (eth_act && !blink_ph) ? COL_OFF : COL_GREEN;
         end else begin
            lnk_nxt = (eth_act && !blink_ph) ? COL_OFF : COL_YELLOW;
         end
      end
   end

   // Session loss shows steady red: the exact pattern is left open
   always_comb begin
      net_nxt = COL_OFF;
      if (net_power_on_test) begin
         net_nxt = flash_ph ? COL_RED : COL_GREEN;
      end else if (net_duplicate_ip) begin
         net_nxt = COL_RED;
      end else if (!net_ip_valid) begin
         net_nxt = COL_OFF;
      end else if (net_session_lost) begin
         net_nxt = COL_RED;
      end else if (net_session_active) begin
         net_nxt = COL_GREEN;
      end else begin
         net_nxt = flash_ph ? COL_GREEN : COL_OFF;
      end
   end

   always_comb begin
      ser_nxt = (ser_act && flash_ph) ? COL_YELLOW : COL_OFF;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Registered lamp outputs

   colour_t drv_r;
   colour_t flt_r;
   colour_t saf_r;
   colour_t lnk_r;
   colour_t net_r;
   colour_t ser_r;

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         drv_r <= COL_OFF;
         flt_r <= COL_OFF;
         saf_r <= COL_OFF;
      end else begin
         drv_r <= drv_nxt;
         flt_r <= flt_nxt;
         saf_r <= saf_nxt;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         lnk_r <= COL_OFF;
         net_r <= COL_OFF;
         ser_r <= COL_OFF;
      end else begin
         lnk_r <= lnk_nxt;
         net_r <= net_nxt;
         ser_r <= ser_nxt;
      end
   end

   assign drive_status_indicator    = drv_r;
   assign fault_indicator           = flt_r;
   assign safety_trip_indicator     = saf_r;
   assign ethernet_link_indicator   = lnk_r;
   assign network_status_indicator  = net_r;
   assign serial_activity_indicator = ser_r;

endmodule

// ### verification/drive_status_led_chk.sv
// Assertion checker for the status lamp encoder
`timescale 1ns/1ns
module drive_status_led_chk
   import led_pkg::*;
(
   // Clock and reset
   input wire logic    ref_clk,
   input wire logic    rst,
   // State flags
   input wire logic    drive_powered,
   input wire logic    drive_transitory,
   input wire logic    drive_running,
   input wire logic    drive_warning,
   input wire logic    drive_error,
   input wire logic    safety_triggered,
   input wire logic    eth_link_up,
   input wire logic    net_power_on_test,
   input wire logic    net_ip_valid,
   input wire logic    net_duplicate_ip,
   // Lamps
   input wire colour_t drive_status_indicator,
   input wire colour_t fault_indicator,
   input wire colour_t safety_trip_indicator,
   input wire colour_t ethernet_link_indicator,
   input wire colour_t network_status_indicator
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (rst);

   chk_dark_unpowered: assert property (!drive_powered |=> drive_status_indicator == COL_OFF)
      else $error("status lamp lit unpowered");
   chk_run_green: assert property (drive_powered && drive_running && !drive_transitory
      |=> drive_status_indicator == COL_GREEN) else $error("run lamp not green");
   chk_error_red: assert property (drive_error |=> fault_indicator == COL_RED)
      else $error("error lamp not red");
   chk_warn_red: assert property (drive_warning |=> fault_indicator inside {COL_OFF, COL_RED})
      else $error("warning lamp colour");
   chk_safety_lamp: assert property (!rst |=> safety_trip_indicator ==
      ($past(safety_triggered) ? COL_YELLOW : COL_OFF)) else $error("safety lamp wrong");
   chk_link_dark: assert property (!eth_link_up |=> ethernet_link_indicator == COL_OFF)
      else $error("link lamp lit without link");
   chk_dup_red: assert property (net_duplicate_ip && !net_power_on_test
      |=> network_status_indicator == COL_RED) else $error("duplicate not red");
   chk_noip_dark: assert property (!net_ip_valid && !net_duplicate_ip && !net_power_on_test
      |=> network_status_indicator == COL_OFF) else $error("network lamp lit without address");
endmodule

bind drive_status_led_encoder drive_status_led_chk u_chk (.ref_clk, .rst, .drive_powered,
   .drive_transitory, .drive_running, .drive_warning, .drive_error, .safety_triggered,
   .eth_link_up, .net_power_on_test, .net_ip_valid, .net_duplicate_ip, .drive_status_indicator,
   .fault_indicator, .safety_trip_indicator, .ethernet_link_indicator, .network_status_indicator);

// ### verification/lamp_viewer.sv
// Operator eye on one lamp: counts changes and keeps the last lit colour
`timescale 1ns/1ns
module lamp_viewer
   import led_pkg::*;
(
   // Clock and clear
   input  wire logic       ref_clk,
   input  wire logic       clr,
   // Watched lamp and what was seen
   input  wire colour_t    lamp,
   output logic      [7:0] changes,
   output logic      [3:0] seen,
   output colour_t         lit
);
   colour_t prev_r;

   always_ff @(posedge ref_clk) begin
      prev_r <= lamp;
      if (clr) changes <= 8'h00;
      else if (lamp != prev_r) changes <= changes + 8'h01;
   end

   // One bit per colour code, so a two-colour pattern can be told from a flash
   always_ff @(posedge ref_clk) begin
      if (clr) seen <= 4'h0;
      else seen[lamp] <= 1'b1;
   end

   always_ff @(posedge ref_clk) begin
      if (clr) lit <= COL_OFF;
      else if (lamp != COL_OFF) lit <= lamp;
   end
endmodule

// ### verification/drive_status_led_encoder_test.sv
// Self-checking bench for the status lamp encoder
`timescale 1ns/1ns
module drive_status_led_encoder_test;
   import led_pkg::*;
   // Window is a multiple of both half periods, so toggle counts are exact
   localparam int FH  = 8;
   localparam int BH  = 3;
   localparam int AH  = 20;
   localparam int WIN = 24;
   logic          ref_clk;
   logic          rst;
   logic          clr;
   logic   [15:0] fl;
   logic    [7:0] changes;
   logic    [3:0] seen;
   int            sel;
   int            num_errors;
   int            check_count;
   colour_t       ds, ft, sf, lk, ns, sr, watch, lit;

   drive_status_led_encoder #(.FLASH_HALF(FH), .BLINK_HALF(BH), .ACT_HOLD(AH)) u_dut (
      .ref_clk, .rst, .drive_powered(fl[15]), .drive_ready(fl[14]), .drive_transitory(fl[13]),
      .drive_running(fl[12]), .drive_warning(fl[11]), .drive_error(fl[10]),
      .safety_triggered(fl[9]), .eth_link_up(fl[8]), .eth_speed_100(fl[7]),
      .eth_traffic(fl[6]), .net_power_on_test(fl[5]), .net_ip_valid(fl[4]),
      .net_duplicate_ip(fl[3]), .net_session_active(fl[2]), .net_session_lost(fl[1]),
      .serial_traffic(fl[0]), .drive_status_indicator(ds), .fault_indicator(ft),
      .safety_trip_indicator(sf), .ethernet_link_indicator(lk),
      .network_status_indicator(ns), .serial_activity_indicator(sr));
   lamp_viewer u_view (.ref_clk, .clr, .lamp(watch), .changes, .seen, .lit);

   always_comb begin
      case (sel)
         0: watch = ds;
         1: watch = ft;
         2: watch = sf;
         3: watch = lk;
         4: watch = ns;
         default: watch = sr;
      endcase
   end

   task cyc(input int n);
      repeat (n) @(posedge ref_clk);
      #2;
   endtask

   task chk(input logic [7:0] got, input logic [7:0] exp);
      check_count++;
      if (got !== exp) begin
         num_errors++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // Lit colour skipped for two-colour patterns, whose last colour depends on phase
   task try(input logic [15:0] f, input int s, input logic [7:0] n, input colour_t c);
      fl = f;
      sel = s;
      // Let any traffic stretch left from the previous case run out first
      cyc(AH + 3);
      clr = 1;
      cyc(1);
      clr = 0;
      cyc(WIN);
      chk(changes, n);
      if (n == 8'h00 || c != COL_OFF) chk(lit, c);
   endtask

   task t_drive;
      try(16'h0000, 0, 8'h00, COL_OFF);
      try(16'h9000, 0, 8'h00, COL_GREEN);
      try(16'hB000, 0, 8'h08, COL_GREEN);
      try(16'hC000, 0, 8'h03, COL_GREEN);
      try(16'h7000, 0, 8'h00, COL_OFF);
      try(16'h0800, 1, 8'h03, COL_RED);
      try(16'h0C00, 1, 8'h00, COL_RED);
      try(16'h0200, 2, 8'h00, COL_YELLOW);
      $display("drive, fault and safety test done");
   endtask

   task t_link;
      try(16'h00C0, 3, 8'h00, COL_OFF);
      try(16'h0180, 3, 8'h00, COL_GREEN);
      try(16'h0100, 3, 8'h00, COL_YELLOW);
      try(16'h01C0, 3, 8'h08, COL_GREEN);
      try(16'h0140, 3, 8'h08, COL_YELLOW);
      $display("link test done");
   endtask

   task t_net;
      try(16'h0006, 4, 8'h00, COL_OFF);
      try(16'h0038, 4, 8'h03, COL_OFF);
      chk({4'h0, seen}, 8'h06);
      try(16'h0018, 4, 8'h00, COL_RED);
      try(16'h0016, 4, 8'h00, COL_RED);
      try(16'h0014, 4, 8'h00, COL_GREEN);
      try(16'h0010, 4, 8'h03, COL_GREEN);
      try(16'h0001, 5, 8'h03, COL_YELLOW);
      cyc(AH);
      try(16'h0000, 5, 8'h00, COL_OFF);
      $display("network and serial test done");
   endtask

   task final_report;
      $display("checks %0d mismatches %0d", check_count, num_errors);
      if (num_errors == 0 && check_count > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   initial begin
      ref_clk = 0;
      forever #20 ref_clk = ~ref_clk;
   end

   initial begin
      num_errors = 0;
      check_count = 0;
      fl = 16'h0000;
      clr = 0;
      sel = 0;
      rst = 1;
      repeat (10) @(posedge ref_clk);
      #2;
      rst = 0;
      t_drive();
      t_link();
      t_net();
      final_report();
   end

   // About 1040 cycles expected; cut off well beyond
   initial begin
      #(40 * 4000);
      num_errors++;
      final_report();
   end
endmodule
